// ### srx_receiver.sv
// Asynchronous serial receiver with 16x sampling, majority vote and read buffer
`timescale 1ns/1ps
`default_nettype none
module srx_receiver
    import srx_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Serial line
    input  wire logic        rx_pin,
    // Control
    input  wire srx_cfg_s    rx_cfg,
    input  wire logic        flag_clear,
    // Read side
    output logic [7:0]       serial_data_buffer,
    output logic             rx_ninth_bit,
    output srx_status_s      rx_status,
    output logic             rx_irq
);
    // Sample clock, sequencing and shift state
    logic [15:0] pre_r;
    logic [15:0] div_last;
    srx_state_e  state_r;
    logic [4:0]  rt_r;
    logic [4:0]  edge_ph_r;
    logic [3:0]  bit_idx_r;
    logic [8:0]  shift_r;
    logic [2:0]  smp_r;
    logic [1:0]  ones_r;
    logic [7:0]  data_part;
    logic [7:0]  frm_cnt_r;
    logic        nine_r, noise_acc_r, prev_bit_r, edge_seen_r, bit_done_r, resynced_r;
    // Filtered line, votes and decoded sampling moments
    logic        rx_lvl, sample_tick, vote_maj, vote_dis;
    logic        start_edge, ver_eval, start_fail, mid_eval, char_done;
    logic        do_resync, all_zero, is_break;

    // Pin crosses into the clock domain; idle line is high
    srx_sync #(
        .RST_VAL   (1'b1)
    ) u_sync (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .async_in  (rx_pin),
        .level_out (rx_lvl)
    );

    // One voter serves start, data and stop windows
    srx_vote u_vote (
        .samples  ({smp_r[1:0], rx_lvl}),
        .majority (vote_maj),
        .disagree (vote_dis)
    );

    // Sample clock from the bus clock; divisor of zero acts as one
    assign div_last    = (rx_cfg.rt_divisor == 16'h0000) ? 16'h0000
                                                           : rx_cfg.rt_divisor - DIV_ONE;
    assign sample_tick = (pre_r >= div_last);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pre_r <= 16'h0000;
        end else if (sample_tick) begin
            pre_r <= 16'h0000;
        end else begin
            pre_r <= pre_r + 16'h0001;
        end
    end

    // Decode of sampling moments
    assign start_edge = sample_tick && rx_cfg.enable && (state_r == SRX_SEARCH)
                     && (ones_r == IDLE_ONES) && !rx_lvl;
    assign ver_eval   = sample_tick && (state_r == SRX_START) && (rt_r == RT_VER_C);
    assign start_fail = ver_eval && vote_maj;
    assign mid_eval   = sample_tick && (state_r != SRX_SEARCH) && (rt_r == RT_MID_C)
                     && !bit_done_r;
    assign char_done  = mid_eval && (state_r == SRX_STOP);
    assign do_resync  = mid_eval && (state_r == SRX_DATA) && prev_bit_r && !vote_maj
                     && edge_seen_r;

    // Data sits high-aligned in 8-bit mode; top bit is bit 8 or bit 7
    assign data_part  = nine_r ? shift_r[7:0] : shift_r[8:1];
    assign all_zero   = nine_r ? (shift_r == 9'h000) : (shift_r[8:1] == 8'h00);
    assign is_break   = char_done && all_zero && !vote_maj;

    // Consecutive-ones counter for the start search
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ones_r <= 2'h0;
        end else if (!rx_cfg.enable || start_fail || char_done) begin
            ones_r <= 2'h0;
        end else if (sample_tick && state_r == SRX_SEARCH) begin
            if (!rx_lvl) begin
                ones_r <= 2'h0;
            end else if (ones_r != IDLE_ONES) begin
                ones_r <= ones_r + 2'h1;
            end
        end
    end

    // Sequencing and sample phase
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r    <= SRX_SEARCH;
            rt_r       <= RT_FIRST;
            bit_idx_r  <= 4'h0;
            nine_r     <= 1'b0;
            bit_done_r <= 1'b0;
        end else if (!rx_cfg.enable) begin
            state_r    <= SRX_SEARCH;
            rt_r       <= RT_FIRST;
            bit_done_r <= 1'b0;
        end else if (start_edge) begin
            state_r    <= SRX_START; // phase aligned to the start edge
            rt_r       <= RT_FIRST + 5'h01; // edge tick is phase 1
            bit_idx_r  <= 4'h0;
            nine_r     <= rx_cfg.nine_bits;
            bit_done_r <= 1'b0;
        end else if (start_fail) begin
            state_r    <= SRX_SEARCH;
            rt_r       <= RT_FIRST;
        end else if (char_done) begin
            state_r    <= SRX_SEARCH;
            rt_r       <= RT_FIRST;
        end else if (sample_tick && state_r != SRX_SEARCH) begin
            if (do_resync) begin
                // Falling edge becomes phase 1; done flag stops a second vote
                rt_r       <= RT_MID_C + 5'h02 - edge_ph_r;
                bit_done_r <= 1'b1;
            end else if (mid_eval) begin
                rt_r       <= rt_r + 5'h01;
                bit_done_r <= 1'b1;
            end else if (rt_r == RT_LAST) begin
                rt_r       <= RT_FIRST;
                bit_done_r <= 1'b0;
                case (state_r)
                    SRX_START: begin
                        state_r <= SRX_DATA;
                    end
                    SRX_DATA: begin
                        if (bit_idx_r == (nine_r ? LAST_BIT_9 : LAST_BIT_8)) begin
                            state_r <= SRX_STOP;
                        end else begin
                            bit_idx_r <= bit_idx_r + 4'h1;
                        end
                    end
                    default: begin
                        state_r <= SRX_SEARCH;
                    end
                endcase
            end else begin
                rt_r <= rt_r + 5'h01;
            end
        end
    end

    // Sample history for the three-sample windows
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            smp_r <= 3'h7;
        end else if (sample_tick && (rt_r == RT_VER_A || rt_r == RT_VER_B
                     || rt_r == RT_MID_A || rt_r == RT_MID_B)) begin
            smp_r <= {smp_r[1:0], rx_lvl};
        end
    end

    // Shift register and one-to-zero edge tracking
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            shift_r     <= 9'h000;
            prev_bit_r  <= 1'b0;
            edge_seen_r <= 1'b0;
            edge_ph_r   <= RT_FIRST;
        end else if (start_edge) begin
            shift_r     <= 9'h000;
            prev_bit_r  <= 1'b0; // start bit is low
            edge_seen_r <= 1'b0;
        end else if (mid_eval && state_r == SRX_DATA) begin
            shift_r     <= {vote_maj, shift_r[8:1]};
            prev_bit_r  <= vote_maj;
        end else if (sample_tick && state_r == SRX_DATA) begin
            if (rt_r == RT_LAST) begin
                edge_seen_r <= 1'b0;
            end else if (prev_bit_r && !rx_lvl && !edge_seen_r && rt_r < RT_MID_A) begin
                edge_seen_r <= 1'b1;
                edge_ph_r   <= rt_r;
            end
        end
    end

    // Noise gathered across the character
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            noise_acc_r <= 1'b0;
        end else if (start_edge) begin
            noise_acc_r <= 1'b0;
        end else if (ver_eval && vote_dis && !vote_maj) begin
            noise_acc_r <= 1'b1;
        end else if (mid_eval && state_r == SRX_START && (smp_r[1:0] != 2'h0 || rx_lvl)) begin
            noise_acc_r <= 1'b1;
        end else if (mid_eval && state_r == SRX_DATA && vote_dis) begin
            noise_acc_r <= 1'b1;
        end
    end

    // Read buffer and ninth bit; a break loads zeros
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            serial_data_buffer <= BUF_RST;
            rx_ninth_bit       <= 1'b0;
        end else if (char_done) begin
            serial_data_buffer <= is_break ? BUF_RST : data_part;
            rx_ninth_bit       <= is_break ? 1'b0 : shift_r[8];
        end
    end

    // Status flags: a new character beats a clear in the same cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_status <= '0;
        end else if (char_done) begin
            rx_status.rx_full_flag       <= 1'b1;
            rx_status.noise_flag         <= rx_status.noise_flag | noise_acc_r
                                          | vote_dis;
            rx_status.framing_error_flag <= rx_status.framing_error_flag
                                          | !vote_maj;
            rx_status.break_flag         <= rx_status.break_flag | is_break;
        end else if (flag_clear) begin
            rx_status <= '0;
        end
    end

    // Level request, no edge capture needed
    assign rx_irq = rx_status.rx_full_flag & rx_cfg.rx_irq_enable;

    // Checking helpers: sample count since the edge, and resync seen
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            frm_cnt_r  <= 8'h00;
            resynced_r <= 1'b0;
        end else if (start_edge) begin
            frm_cnt_r  <= 8'h01;
            resynced_r <= 1'b0;
        end else if (sample_tick && state_r != SRX_SEARCH) begin
            frm_cnt_r  <= frm_cnt_r + 8'h01;
            resynced_r <= resynced_r | do_resync;
        end
    end

    sequence s_done;
        char_done && rx_cfg.enable;
    endsequence
    sequence s_loaded;
        rx_status.rx_full_flag ##0 (serial_data_buffer == $past(data_part));
    endsequence
    property p_irq;
        @(posedge clock) disable iff (sys_rst)
        rx_irq == (rx_status.rx_full_flag && rx_cfg.rx_irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq does not follow full flag and enable");

    property p_load;
        @(posedge clock) disable iff (sys_rst)
        (s_done and !is_break) |=> s_loaded;
    endproperty
    a_load: assert property (p_load) else $error("character not loaded with full flag");
    property p_ninth;
        @(posedge clock) disable iff (sys_rst)
        (s_done and !is_break && !nine_r) |=> rx_ninth_bit == serial_data_buffer[7];
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit not copy of bit 7");
    property p_fe_with_full;
        @(posedge clock) disable iff (sys_rst)
        $rose(rx_status.framing_error_flag) |-> $rose(rx_status.rx_full_flag)
                                                || $past(char_done);
    endproperty
    a_fe_with_full: assert property (p_fe_with_full) else $error("framing error without full");

    property p_break;
        @(posedge clock) disable iff (sys_rst)
        is_break |=> serial_data_buffer == BUF_RST && !rx_ninth_bit
                     && rx_status.break_flag && rx_status.framing_error_flag;
    endproperty
    a_break: assert property (p_break) else $error("break effects missing");
    property p_start_fail;
        @(posedge clock) disable iff (sys_rst)
        start_fail |=> state_r == SRX_SEARCH && rt_r == RT_FIRST && ones_r == 2'h0;
    endproperty
    a_start_fail: assert property (p_start_fail) else $error("failed start not abandoned");
    property p_frame_len;
        @(posedge clock) disable iff (sys_rst)
        (char_done && !resynced_r) |->
            (frm_cnt_r + 8'h01) == (nine_r ? FRAME_RT_9 : FRAME_RT_8);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("stop sampling at wrong count");

    property p_phase_range;
        @(posedge clock) disable iff (sys_rst)
        state_r != SRX_SEARCH |-> rt_r >= RT_FIRST && rt_r <= RT_LAST;
    endproperty
    a_phase_range: assert property (p_phase_range) else $error("sample phase out of range");

    property p_noise_shown;
        @(posedge clock) disable iff (sys_rst)
        (char_done && noise_acc_r) |=> rx_status.noise_flag && rx_status.rx_full_flag;
    endproperty
    a_noise_shown: assert property (p_noise_shown) else $error("noise lost at completion");

    property p_full_holds;
        @(posedge clock) disable iff (sys_rst)
        (rx_status.rx_full_flag && !flag_clear) |=> rx_status.rx_full_flag;
    endproperty
    a_full_holds: assert property (p_full_holds) else $error("full flag dropped uncleared");

endmodule : srx_receiver
`default_nettype wire

// ### srx_pkg.sv
// Shared constants and types for the asynchronous serial receiver
package srx_pkg;

    // Sample clock phases within one bit time
    localparam logic [4:0] RT_FIRST  = 5'h01;
    localparam logic [4:0] RT_VER_A  = 5'h03;
    localparam logic [4:0] RT_VER_B  = 5'h05;
    localparam logic [4:0] RT_VER_C  = 5'h07;
    localparam logic [4:0] RT_MID_A  = 5'h08;
    localparam logic [4:0] RT_MID_B  = 5'h09;
    localparam logic [4:0] RT_MID_C  = 5'h0a;
    localparam logic [4:0] RT_LAST   = 5'h10;

    // Character lengths, as index of the last data bit
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;

    // Consecutive ones that must precede a start edge
    localparam logic [1:0] IDLE_ONES  = 2'h3;

    // Sample cycles from start edge to end of stop sampling
    localparam logic [7:0] FRAME_RT_8 = 8'h9a;
    localparam logic [7:0] FRAME_RT_9 = 8'haa;

    // Reset value of the read buffer; step of one taken off the divisor
    localparam logic [7:0]  BUF_RST   = 8'h00;
    localparam logic [15:0] DIV_ONE   = 16'h0001;

    // Receiver sequencing
    typedef enum logic [1:0] {
        SRX_SEARCH,
        SRX_START,
        SRX_DATA,
        SRX_STOP
    } srx_state_e;

    // Control inputs
    typedef struct packed {
        logic        enable;
        logic        nine_bits;
        logic        rx_irq_enable;
        logic [15:0] rt_divisor;
    } srx_cfg_s;

    // Status outputs
    typedef struct packed {
        logic rx_full_flag;
        logic noise_flag;
        logic framing_error_flag;
        logic break_flag;
    } srx_status_s;

endpackage : srx_pkg

// ### srx_sync.sv
// Three-stage synchroniser with agreement filter for the receive pin
`timescale 1ns/1ps
`default_nettype none
module srx_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Pin and filtered level
    input  wire logic async_in,
    output logic      level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // First stage feeds only the second
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Level changes only once two later stages agree
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            level_out <= RST_VAL;
        end else if (s2_r == s3_r) begin
            level_out <= s3_r;
        end
    end
endmodule : srx_sync
`default_nettype wire

// ### srx_vote.sv
// Majority and disagreement of three line samples
`timescale 1ns/1ps
`default_nettype none
module srx_vote (
    // Three samples, oldest in bit 2
    input  wire logic [2:0] samples,
    // Results
    output logic            majority,
    output logic            disagree
);
    // Two or more ones win; any mix counts as noise
    assign majority = (samples[2] & samples[1]) | (samples[2] & samples[0])
                    | (samples[1] & samples[0]);
    assign disagree = (samples != 3'h0) && (samples != 3'h7);
endmodule : srx_vote
`default_nettype wire

// ### srx_tx_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module srx_tx_model (
    // Clock and slice length in clock cycles, same as the receiver divisor
    input  wire logic        clock,
    input  wire logic [15:0] slice_clks,
    // Serial line, idle high like a pulled-up wire
    output var logic         line
);

    // Line rests at the mark level until a character is asked for
    initial begin
        line = 1'b1;
    end

    // One sixteenth of a bit; the level moves only at the falling clock edge
    task automatic slice(input logic lvl);
        line = lvl;
        repeat (slice_clks) @(negedge clock);
    endtask : slice

    // Mark slices so the receiver sees three ones ahead of the next start
    task automatic idle(input int n);
        repeat (n) slice(1'b1);
    endtask : idle

    // Start, data LSB first, stop; one bit may carry a run of flipped slices
    task automatic send_char(input logic [8:0] d, input logic nine, input logic stop_lvl,
                             input int nb, input int np, input int nw);
        logic [10:0] frame;
        int          last;
        logic        lvl;
        last        = nine ? 10 : 9;
        frame       = {1'b1, d, 1'b0};
        frame[last] = stop_lvl;
        // Sixteen slices per bit, so a noisy slice lands on one sample phase
        for (int b = 0; b <= last; b++) begin
            for (int ph = 1; ph <= 16; ph++) begin
                lvl = (b == nb && ph >= np && ph < np + nw) ? ~frame[b] : frame[b];
                slice(lvl);
            end
        end
        // Stop level stays; a low stop is followed by idle slices from the caller
    endtask : send_char

endmodule : srx_tx_model
`default_nettype wire

// ### async_serial_receiver_tb.sv
// Self-checking bench for the serial receiver with a queue-based reference
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
    comparisons++; \
    if ((a) !== (e)) begin \
        n_errors++; \
        $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); \
    end \
end
module async_serial_receiver_tb
    import srx_pkg::*;
;
    localparam int TMO = 60000;

    // One expected character, queued when it is sent
    typedef struct {
        logic [7:0] data;
        logic       ninth;
        logic [3:0] status;
        logic       irq;
        int         len;
        longint     t0;
    } srx_exp_s;

    logic        clock;
    logic        sys_rst;
    logic        rx_pin;
    srx_cfg_s    rx_cfg;
    logic        flag_clear;
    logic [7:0]  serial_data_buffer;
    logic        rx_ninth_bit;
    srx_status_s rx_status;
    logic        rx_irq;
    int          n_errors;
    int          comparisons;
    srx_exp_s    exp_q[$];

    srx_receiver uut (
        .clock              (clock),
        .sys_rst            (sys_rst),
        .rx_pin             (rx_pin),
        .rx_cfg             (rx_cfg),
        .flag_clear         (flag_clear),
        .serial_data_buffer (serial_data_buffer),
        .rx_ninth_bit       (rx_ninth_bit),
        .rx_status          (rx_status),
        .rx_irq             (rx_irq)
    );

    srx_tx_model far_end (
        .clock      (clock),
        .slice_clks (rx_cfg.rt_divisor),
        .line       (rx_pin)
    );

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Closing report and verdict
    task automatic end_sim();
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // Reference result worked out from the character, then the line is driven
    task automatic send(input logic [8:0] d, input logic nine, input logic stp,
                        input int nb = -1, input int np = 0, input int nw = 0);
        srx_exp_s   e;
        logic [8:0] dm;
        dm       = nine ? d : {1'b0, d[7:0]};
        e.data   = dm[7:0];
        e.ninth  = nine ? dm[8] : dm[7];
        e.status = {1'b1, nw > 0, !stp, (dm == 9'h000) && !stp};
        e.irq    = rx_cfg.rx_irq_enable;
        e.len    = nine ? 170 : 154;
        e.t0     = $time;
        exp_q.push_back(e);
        rx_cfg.nine_bits = nine;
        far_end.send_char(dm, nine, stp, nb, np, nw);
    endtask : send

    // Wait for the next character, compare it, then clear the flags
    task automatic check_one();
        srx_exp_s e;
        longint   dt;
        int       k;
        int       div_clks;
        k = 0;
        while (rx_status.rx_full_flag !== 1'b1 && k < 4000) begin
            @(negedge clock);
            k++;
        end
        e  = exp_q.pop_front();
        dt = ($time - e.t0) / 10;
        div_clks = int'(rx_cfg.rt_divisor);
        `CHK(serial_data_buffer, e.data)
        `CHK(rx_ninth_bit, e.ninth)
        `CHK(rx_status, e.status)
        `CHK(rx_irq, e.irq)
        `CHK(dt >= (e.len - 1) * div_clks && dt <= e.len * div_clks + 8, 1'b1)
        flag_clear = 1'b1;
        @(negedge clock);
        flag_clear = 1'b0;
        @(negedge clock);
        `CHK({rx_status, rx_irq}, 5'h00)
    endtask : check_one

    // Main sequence
    initial begin
        n_errors    = 0;
        comparisons = 0;
        sys_rst     = 1'b1;
        flag_clear  = 1'b0;
        void'($urandom(32'h865626e4));
        // Random bit period, so the sample clock divider is exercised as well
        rx_cfg      = '{enable: 1'b1, nine_bits: 1'b0, rx_irq_enable: 1'b1,
                        rt_divisor: 16'h0006 + 16'($urandom_range(4))};
        repeat (2) @(negedge clock);
        sys_rst = 1'b0;
        `CHK({serial_data_buffer, rx_ninth_bit, rx_status, rx_irq}, 14'h0000)
        far_end.idle(4);
        // Back-to-back traffic, breaks, framing error and noise placements
        fork
            begin
                for (int i = 0; i < 6; i++) begin
                    rx_cfg.rx_irq_enable = 1'($urandom);
                    send(9'($urandom), i[0], 1'b1);
                end
                send(9'h100, 1'b0, 1'b0);
                far_end.idle(4);
                send(9'h000, 1'b1, 1'b0);
                far_end.idle(4);
                send(9'h0a5, 1'b0, 1'b0);
                far_end.idle(4);
                send(9'($urandom), 1'b0, 1'b1, 0, 4, 2);
                send(9'($urandom), 1'b0, 1'b1, 0, 9, 1);
                send(9'($urandom), 1'b1, 1'b1, 3, 9, 1);
                send(9'($urandom), 1'b1, 1'b1, 10, 9, 1);
            end
            repeat (13) check_one();
        join
        // Short false start, then a character with the interrupt masked
        rx_cfg.rx_irq_enable = 1'b0;
        far_end.slice(1'b0);
        far_end.slice(1'b0);
        far_end.idle(8);
        fork
            send(9'($urandom), 1'b1, 1'b1);
            check_one();
        join
        // Receiver disabled: the line must be ignored
        rx_cfg.enable        = 1'b0;
        rx_cfg.rx_irq_enable = 1'b1;
        far_end.send_char(9'h055, 1'b0, 1'b1, -1, 0, 0);
        repeat (20) @(negedge clock);
        `CHK(rx_status.rx_full_flag, 1'b0)
        end_sim();
    end

    // Watchdog sized well beyond the expected run
    initial begin
        repeat (TMO) @(posedge clock);
        n_errors++;
        end_sim();
    end

endmodule : async_serial_receiver_tb
`undef CHK
`default_nettype wire
